// ===== core/sensor_host_pkg.sv
// constants and types shared by the sensor serial host controller
`default_nettype none

package sensor_host_pkg;

  // system clock and the fastest link rates the sensor accepts
  localparam int CLK_KHZ     = 100000;
  localparam int I2C_MAX_KHZ = 400;
  localparam int SPI_MAX_KHZ = 10000;
  localparam int QUARTERS    = 4;

  // quarter bit period in clock cycles, rounded up so the rate never exceeds
  localparam int I2C_QTR =
    (CLK_KHZ + I2C_MAX_KHZ * QUARTERS - 1) / (I2C_MAX_KHZ * QUARTERS);
  localparam int SPI_QTR =
    (CLK_KHZ + SPI_MAX_KHZ * QUARTERS - 1) / (SPI_MAX_KHZ * QUARTERS);
  localparam int QTR_W = 8;

  // upper six bits of the two-wire slave address, low bit is the strap
  localparam logic [5:0] DEV_ADDR_HI = 6'h34;
  localparam logic       RW_WRITE    = 1'b0;
  localparam logic       RW_READ     = 1'b1;

  // bit slots within one byte
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // quarter steps of every bit
  localparam logic [1:0] Q_SETUP  = 2'h0;
  localparam logic [1:0] Q_RISE   = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL   = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} state_t;
  typedef enum logic [1:0] {PH_ADDR, PH_INDEX, PH_RADDR, PH_DATA} phase_t;

endpackage

`default_nettype wire

// ===== core/pin_sync.sv
// two-flop synchroniser for pins driven by the sensor
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  // raw pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] pins_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_t;

  sync_t r_q;
  sync_t r_d;

  // first stage feeds only the second stage
  always_comb begin
    r_d      = r_q;
    r_d.meta = pins_in;
    r_d.sync = r_q.meta;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r_q <= '{default: '1};
    end else begin
      r_q <= r_d;
    end
  end

  assign pins_out = r_q.sync;

endmodule // pin_sync

`default_nettype wire

// ===== core/clk_divider.sv
// quarter-bit tick generator that paces the link clock
`default_nettype none

module clk_divider #(
  parameter int SLOW_QTR = sensor_host_pkg::I2C_QTR,
  parameter int FAST_QTR = sensor_host_pkg::SPI_QTR
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // rate select and tick
  input  wire logic fast_in,
  output logic      tick_out
);

  localparam int W = sensor_host_pkg::QTR_W;
  localparam logic [W-1:0] SLOW_LAST = W'(SLOW_QTR - 1);
  localparam logic [W-1:0] FAST_LAST = W'(FAST_QTR - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_t;

  div_t r_q;
  div_t r_d;

  // one tick every quarter period of the selected rate
  always_comb begin
    r_d      = r_q;
    r_d.tick = 1'b0;
    if (r_q.cnt >= (fast_in ? FAST_LAST : SLOW_LAST)) begin
      r_d.cnt  = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.cnt = r_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign tick_out = r_q.tick;

endmodule // clk_divider

`default_nettype wire

// ===== core/sensor_host.sv
// host controller that reads and writes sensor registers over i2c or spi
//
// How it works
// - two-wire clock never above 400 kHz
// - start: data falls while clock high
// - stop: data rises while clock high
// - repeated start keeps bus, new address
// - eight bit bytes, each acknowledged, any count; host moves 1 to 256 data bytes per request
// - ack is data low through ninth clock
// - first byte is address plus direction bit
// - data changes only while clock low
// - write: address, index, data, acks, stop
// - read: address, index, repeated start, read address
// - host acks bytes, nacks last, then stops
// - select low for the whole spi transaction
// - spi bytes go most significant bit first
// - sample on rising, change on falling edge
// - spi clock never above 10 MHz
// - spi: direction bit, 7-bit index, data
// - two-wire disable bit guards spi use
`default_nettype none

module sensor_host (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // request
  input  wire logic       req_in,
  input  wire logic       spi_mode_in,
  input  wire logic       read_in,
  input  wire logic [6:0] index_in,
  input  wire logic [7:0] len_in,
  input  wire logic       addr_lsb_select_pin_in,
  input  wire logic       two_wire_port_disable_in,
  // write data
  input  wire logic [7:0] wr_data_in,
  output logic            wr_take_out,
  // answer
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out,
  output logic            busy_out,
  output logic            done_out,
  output logic            nack_out,
  output logic            refused_out,
  // shared clock line: scl or sclk
  input  wire logic       clk_line_in,
  output logic            clk_line_out,
  output logic            clk_line_oe_out,
  // shared data line: sda or mosi
  input  wire logic       data_line_in,
  output logic            data_line_out,
  output logic            data_line_oe_out,
  // spi only pins
  input  wire logic       spi_miso_in,
  output logic            device_select_low_out
);

  typedef struct packed {
    sensor_host_pkg::state_t st;
    sensor_host_pkg::phase_t ph;
    logic [1:0]              qtr;
    logic [3:0]              bit_n;
    logic [7:0]              sh;
    logic [7:0]              left;
    logic [6:0]              idx;
    logic                    spi;
    logic                    rd;
    logic                    lsb;
    logic                    rx;
    logic                    clk_oe;
    logic                    clk_val;
    logic                    dat_oe;
    logic                    dat_val;
    logic                    cs_n;
    logic                    take;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    done;
    logic                    nack;
    logic                    refused;
    logic                    busy;
  } host_t;

  host_t r;
  host_t n;

  logic [2:0] pins_s;
  logic       tick;
  logic       scl_ok;
  logic       tx_phase;
  logic [7:0] shifted;
  logic       i2c_bit;

  // two-wire address byte with the direction bit appended
  function automatic logic [7:0] addr_byte(input logic lsb, input logic rw);
    addr_byte = {sensor_host_pkg::DEV_ADDR_HI, lsb, rw};
  endfunction

  // pins from the sensor cross into our clock domain first
  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock_in(clock_in),
    .rst_in  (rst_in),
    .pins_in ({clk_line_in, data_line_in, spi_miso_in}),
    .pins_out(pins_s)
  );

  // link clock is derived here, never taken from the far side
  clk_divider #(
    .SLOW_QTR(sensor_host_pkg::I2C_QTR),
    .FAST_QTR(sensor_host_pkg::SPI_QTR)
  ) u_div (
    .clock_in(clock_in),
    .rst_in  (rst_in),
    .fast_in (r.spi),
    .tick_out(tick)
  );

  // a stretched scl holds the sample quarter; spi has no stretching
  assign scl_ok   = r.spi | pins_s[2];
  assign tx_phase = !(r.rd && r.ph == sensor_host_pkg::PH_DATA);
  assign shifted  = {r.sh[6:0], r.rx};
  assign i2c_bit  = (r.st == sensor_host_pkg::ST_BIT) && !r.spi;

  // controller state machine, one quarter bit per tick
  always_comb begin
    n         = r;
    n.take    = 1'b0;
    n.rvalid  = 1'b0;
    n.done    = 1'b0;
    n.refused = 1'b0;
    if (tick && r.st != sensor_host_pkg::ST_IDLE &&
        !(r.qtr == sensor_host_pkg::Q_SAMPLE && !scl_ok)) begin
      n.qtr = r.qtr + 2'h1;
    end
    case (r.st)
      sensor_host_pkg::ST_IDLE: begin
        if (req_in) begin
          if (!spi_mode_in && two_wire_port_disable_in) begin
            n.refused = 1'b1;
          end else begin
            n.st    = sensor_host_pkg::ST_START;
            n.spi   = spi_mode_in;
            n.rd    = read_in;
            n.left  = len_in;
            n.lsb   = addr_lsb_select_pin_in;
            n.idx   = index_in;
            n.qtr   = sensor_host_pkg::Q_SETUP;
            n.nack  = 1'b0;
            n.busy  = 1'b1;
            n.ph    = spi_mode_in ? sensor_host_pkg::PH_INDEX
                                  : sensor_host_pkg::PH_ADDR;
            n.sh    = spi_mode_in ? {read_in, index_in}
                                  : addr_byte(addr_lsb_select_pin_in,
                                              sensor_host_pkg::RW_WRITE);
          end
        end
      end
      sensor_host_pkg::ST_START: begin
        if (tick) begin
          if (r.spi) begin
            if (r.qtr == sensor_host_pkg::Q_SETUP) begin
              n.clk_oe  = 1'b1;
              n.clk_val = 1'b0;
              n.dat_oe  = 1'b1;
              n.dat_val = 1'b0;
              n.cs_n    = 1'b0;
            end
          end else begin
            case (r.qtr)
              sensor_host_pkg::Q_SETUP:  n.dat_oe = 1'b0;
              sensor_host_pkg::Q_RISE:   n.clk_oe = 1'b0;
              sensor_host_pkg::Q_SAMPLE: n.dat_oe = scl_ok;
              default:                   n.clk_oe = 1'b1;
            endcase
          end
          if (r.qtr == sensor_host_pkg::Q_FALL) begin
            n.st    = sensor_host_pkg::ST_BIT;
            n.bit_n = '0;
          end
        end
      end
      sensor_host_pkg::ST_BIT: begin
        if (tick) begin
          case (r.qtr)
            // data moves only here, while the clock is low
            sensor_host_pkg::Q_SETUP: begin
              if (r.spi) begin
                n.dat_val = tx_phase & r.sh[7];
              end else if (r.bit_n == sensor_host_pkg::ACK_SLOT) begin
                n.dat_oe = !tx_phase && (r.left != 8'h00);
              end else begin
                n.dat_oe = tx_phase && !r.sh[7];
              end
            end
            sensor_host_pkg::Q_RISE: begin
              n.clk_oe  = r.spi;
              n.clk_val = r.spi;
            end
            sensor_host_pkg::Q_SAMPLE: begin
              if (scl_ok) begin
                n.rx = r.spi ? pins_s[0] : pins_s[1];
              end
            end
            default: begin
              n.clk_oe  = 1'b1;
              n.clk_val = 1'b0;
              if (r.bit_n <= sensor_host_pkg::LAST_BIT) begin
                n.sh = shifted;
              end
              if (r.bit_n != (r.spi ? sensor_host_pkg::LAST_BIT
                                    : sensor_host_pkg::ACK_SLOT)) begin
                n.bit_n = r.bit_n + 4'h1;
              end else begin
                n.bit_n = '0;
                if (!r.spi && tx_phase && r.rx) begin
                  n.nack = 1'b1; // sensor did not ack, end it
                  n.st   = sensor_host_pkg::ST_STOP;
                end else begin
                  case (r.ph)
                    sensor_host_pkg::PH_ADDR: begin
                      n.ph = sensor_host_pkg::PH_INDEX;
                      n.sh = {1'b0, r.idx};
                    end
                    sensor_host_pkg::PH_INDEX: begin
                      if (r.rd && !r.spi) begin
                        n.st = sensor_host_pkg::ST_START;
                        n.ph = sensor_host_pkg::PH_RADDR;
                        n.sh = addr_byte(r.lsb, sensor_host_pkg::RW_READ);
                      end else if (r.rd) begin
                        n.ph = sensor_host_pkg::PH_DATA;
                        n.sh = '0;
                      end else begin
                        n.ph   = sensor_host_pkg::PH_DATA;
                        n.sh   = wr_data_in;
                        n.take = 1'b1;
                      end
                    end
                    sensor_host_pkg::PH_RADDR: begin
                      n.ph = sensor_host_pkg::PH_DATA;
                      n.sh = '0;
                    end
                    default: begin
                      if (r.rd) begin
                        n.rdata  = r.spi ? shifted : r.sh;
                        n.rvalid = 1'b1;
                      end
                      if (r.left == 8'h00) begin
                        n.st = sensor_host_pkg::ST_STOP;
                      end else begin
                        // sensor bumps its index per byte
                        n.left = r.left - 8'h01;
                        n.sh   = r.rd ? 8'h00 : wr_data_in;
                        n.take = !r.rd;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      sensor_host_pkg::ST_STOP: begin
        if (tick) begin
          case (r.qtr)
            sensor_host_pkg::Q_SETUP: begin
              n.clk_oe  = 1'b1;
              n.clk_val = 1'b0;
              n.dat_oe  = 1'b1;
              n.dat_val = 1'b0;
            end
            sensor_host_pkg::Q_RISE:   n.clk_oe = r.spi;
            sensor_host_pkg::Q_SAMPLE: n.dat_oe = r.spi || !scl_ok;
            default: begin
              n.cs_n   = 1'b1;
              n.clk_oe = 1'b0;
              n.dat_oe = 1'b0;
              n.st     = sensor_host_pkg::ST_IDLE;
              n.done   = 1'b1;
              n.busy   = 1'b0;
            end
          endcase
        end
      end
      default: n.st = sensor_host_pkg::ST_IDLE;
    endcase
  end

  // async reset loads constants only; select idles high
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r      <= '0;
      r.st   <= sensor_host_pkg::ST_IDLE;
      r.ph   <= sensor_host_pkg::PH_ADDR;
      r.cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // open-drain on i2c: value is low, enable pulls; spi drives both ways
  assign clk_line_out          = r.clk_val;
  assign clk_line_oe_out       = r.clk_oe;
  assign data_line_out         = r.dat_val;
  assign data_line_oe_out      = r.dat_oe;
  assign device_select_low_out = r.cs_n;
  assign wr_take_out           = r.take;
  assign rd_data_out           = r.rdata;
  assign rd_valid_out          = r.rvalid;
  assign busy_out              = r.busy;
  assign done_out              = r.done;
  assign nack_out              = r.nack;
  assign refused_out           = r.refused;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence scl_high_s;
    i2c_bit && !r.clk_oe;
  endsequence

  sequence sclk_rise_s;
    r.spi && $rose(r.clk_val);
  endsequence

  data_stable_a: assert property (
    scl_high_s ##1 scl_high_s |-> $stable(r.dat_oe))
    else $error("data moved while scl high");

  start_cond_a: assert property (
    !r.spi && $rose(r.dat_oe) && !r.clk_oe
    |-> r.st == sensor_host_pkg::ST_START)
    else $error("sda fell with scl high outside start");

  stop_cond_a: assert property (
    !r.spi && $fell(r.dat_oe) && !r.clk_oe
    |-> r.st == sensor_host_pkg::ST_STOP)
    else $error("sda rose with scl high outside stop");

  select_held_a: assert property (
    r.spi && r.st == sensor_host_pkg::ST_BIT |-> !r.cs_n)
    else $error("select high during spi byte");

  tick_spacing_a: assert property (
    tick |=> !tick ##1 !tick)
    else $error("link clock quarter too short");

  ack_release_a: assert property (
    i2c_bit && r.bit_n == sensor_host_pkg::ACK_SLOT && tx_phase &&
    r.qtr != sensor_host_pkg::Q_SETUP |-> !r.dat_oe)
    else $error("host drove sda in sensor ack slot");

  master_ack_a: assert property (
    i2c_bit && r.bit_n == sensor_host_pkg::ACK_SLOT && !tx_phase &&
    r.qtr != sensor_host_pkg::Q_SETUP |-> r.dat_oe == (r.left != 8'h00))
    else $error("wrong host ack or nack");

  address_byte_a: assert property (
    i2c_bit && r.bit_n == 4'h0 && (r.ph == sensor_host_pkg::PH_ADDR ||
    r.ph == sensor_host_pkg::PH_RADDR) |-> r.sh[7:2] ==
    sensor_host_pkg::DEV_ADDR_HI && r.sh[1] == r.lsb &&
    r.sh[0] == (r.ph == sensor_host_pkg::PH_RADDR))
    else $error("bad two-wire address byte");

  stretch_wait_a: assert property (
    i2c_bit && r.qtr == sensor_host_pkg::Q_SAMPLE && !scl_ok
    |=> r.qtr == sensor_host_pkg::Q_SAMPLE)
    else $error("host ran on while scl stretched");

  spi_edge_a: assert property (
    sclk_rise_s |-> $stable(r.dat_val) ##1 r.clk_val)
    else $error("mosi changed on rising sclk");

endmodule // sensor_host

`default_nettype wire

// ===== verif/sensor_model.sv
// behavioural sensor: two-wire and four-wire register port, slave only
`default_nettype none

module sensor_model (
  // shared wires as resolved by the bench
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic sel_low_in,
  // strap and test knobs
  input  wire logic strap_in,
  input  wire logic i2c_off_in,
  input  wire logic stretch_in,
  // lines the sensor pulls or drives
  output logic      pull_out,
  output logic      hold_out,
  output logic      miso_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [0:127];
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hFF;
  logic [6:0] ri = 7'h00;
  logic [3:0] cnt = 4'hF;
  logic [2:0] sb = 3'h0;
  logic [1:0] ph = 2'h0;
  logic       sel = 1'b0, rd = 1'b0, mack = 1'b0, first = 1'b0;
  logic       pull = 1'b0, hold = 1'b0, miso = 1'b1, on;

  // two-wire logic only while unselected and not disabled
  assign on = sel_low_in & ~i2c_off_in;
  assign pull_out = pull & on;
  assign hold_out = hold & on;
  // floating output shows the inverse of its last bit
  assign miso_out = sel_low_in ? ~miso : miso;

  // start or repeated start opens an address phase
  always @(negedge sda_in) if (on && scl_in) begin
    cnt = 4'hF;
    ph = 2'h0;
    pull = 1'b0;
  end
  // stop frees the port
  always @(posedge sda_in) if (on && scl_in) begin
    sel = 1'b0;
    pull = 1'b0;
  end
  // sample data, or the host's acknowledge of a read byte
  always @(posedge scl_in) if (on) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda_in};
    else if (ph == 2'h3) mack = ~sda_in;
  end
  // all changes happen while the clock is low
  always @(negedge scl_in) if (on) begin
    if (stretch_in) begin
      hold = 1'b1; // not ready: keep the clock low
      hold <= #3000 1'b0; // outlasts four quarters, so the host must wait
    end
    if (cnt == 4'h7) begin
      cnt = 4'h8;
      pull = 1'b0;
      if (ph == 2'h0) begin
        sel = sh[7:1] == {6'h34, strap_in};
        rd = sh[0];
      end else if (ph == 2'h1) ri = sh[6:0];
      else if (ph == 2'h2) begin
        mem[ri] = sh;
        ri = ri + 7'h01; // burst advances the index
      end
      if (ph != 2'h3) pull = sel; // low through the ninth clock
    end else if (cnt == 4'h8) begin
      cnt = 4'h0;
      pull = 1'b0;
      if (ph == 2'h0 && sel) begin
        ph = rd ? 2'h3 : 2'h1;
        mack = 1'b1;
      end else if (ph == 2'h1) ph = 2'h2;
      if (ph == 2'h3 && sel) begin
        if (mack) begin
          tx = mem[ri];
          ri = ri + 7'h01;
        end else sel = 1'b0;
        pull = sel & ~tx[7];
      end
    end else begin
      cnt = cnt + 4'h1;
      tx = {tx[6:0], 1'b1};
      pull = sel && ph == 2'h3 && !tx[7];
    end
  end

  // four-wire frame begins with select low
  always @(negedge sel_low_in) begin
    sb = 3'h0;
    first = 1'b1;
  end
  // shift in on the rising edge, msb first
  always @(posedge scl_in) if (!sel_low_in) begin
    sh = {sh[6:0], sda_in};
    sb = sb + 3'h1;
    if (sb == 3'h0) begin
      if (first) begin
        rd = sh[7]; // direction, then 7-bit index
        ri = sh[6:0];
      end else if (!rd) begin
        mem[ri] = sh;
        ri = ri + 7'h01;
      end
      if (rd) begin
        tx = mem[ri];
        ri = ri + 7'h01;
      end
      first = 1'b0;
    end
  end
  // output changes on the falling edge
  always @(negedge scl_in) if (!sel_low_in) begin
    miso = tx[7];
    tx = {tx[6:0], 1'b0};
  end
endmodule // sensor_model

`default_nettype wire

// ===== verif/sensor_host_tb.sv
// self-checking bench for the sensor serial host controller
`default_nettype none

module sensor_host_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clock_in = 1'b0, rst_in = 1'b1, req = 1'b0, spi = 1'b0;
  logic       rd = 1'b0, strap = 1'b1, dis = 1'b0, stretch = 1'b0;
  logic [6:0] index = 7'h00;
  logic [7:0] len = 8'h00, wr_data = 8'h00, rd_data;
  logic       wr_take, rd_valid, busy, done, nack, refused;
  logic       clk_o, clk_oe, dat_o, dat_oe, miso, sel_n;
  logic       pull, hold, scl, sda;
  logic [7:0] rq [$];
  logic [7:0] wq [$];
  int         failures = 0, cmp_count = 0, starts = 0, stops = 0;
  realtime    t_last = 0, per_min = 1e9;

  always #5 clock_in = ~clock_in;
  // open-drain wires with pull-ups, the sensor may pull either low
  assign scl = (clk_oe ? clk_o : 1'b1) & ~hold;
  assign sda = (dat_oe ? dat_o : 1'b1) & ~pull;

  sensor_host i_sensor_host (.clock_in(clock_in), .rst_in(rst_in),
    .req_in(req), .spi_mode_in(spi), .read_in(rd), .index_in(index),
    .len_in(len), .addr_lsb_select_pin_in(strap),
    .two_wire_port_disable_in(dis), .wr_data_in(wr_data),
    .wr_take_out(wr_take), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .busy_out(busy), .done_out(done),
    .nack_out(nack), .refused_out(refused), .clk_line_in(scl),
    .clk_line_out(clk_o), .clk_line_oe_out(clk_oe), .data_line_in(sda),
    .data_line_out(dat_o), .data_line_oe_out(dat_oe),
    .spi_miso_in(miso), .device_select_low_out(sel_n));

  sensor_model i_sensor_model (.scl_in(scl), .sda_in(sda),
    .sel_low_in(sel_n), .strap_in(1'b1), .i2c_off_in(dis),
    .stretch_in(stretch), .pull_out(pull), .hold_out(hold),
    .miso_out(miso));

  // collect read bytes, feed the next write byte after each take
  always @(posedge clock_in) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (wr_take === 1'b1 && wq.size() > 1) begin
      void'(wq.pop_front());
      wr_data <= #1 wq[0];
    end
  end
  // wire watchers: conditions and shortest clock period
  always @(negedge sda) if (scl === 1'b1 && sel_n === 1'b1) starts++;
  always @(posedge sda) if (scl === 1'b1 && sel_n === 1'b1) stops++;
  always @(posedge scl) begin
    if ($realtime - t_last < per_min) per_min = $realtime - t_last;
    t_last = $realtime;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one request, then wait for done under a bounded count
  task automatic run(input logic s, r, input logic [6:0] i,
                     input logic [7:0] n);
    int k;
    k = 0;
    rq.delete();
    starts = 0;
    stops = 0;
    per_min = 1e9;
    spi = s;
    rd = r;
    index = i;
    len = n;
    wr_data = wq[0];
    req = 1'b1;
    @(posedge clock_in);
    #1 req = 1'b0;
    while (done !== 1'b1 && k < 40000) begin
      @(posedge clock_in);
      #1 k++;
    end
    chk("done", 8'h01, {7'h00, done});
  endtask

  task automatic t_reset();
    chk("idle pins", 8'h08, {4'h0, sel_n, busy, clk_oe, dat_oe});
    $display("test reset finished");
  endtask

  task automatic t_i2c_write();
    wq = '{8'h11, 8'h22, 8'h33};
    run(1'b0, 1'b0, 7'h7E, 8'h02);
    chk("mem 7E", 8'h11, i_sensor_model.mem[7'h7E]);
    chk("mem 7F", 8'h22, i_sensor_model.mem[7'h7F]);
    chk("mem 00", 8'h33, i_sensor_model.mem[7'h00]);
    chk("start stop", 8'h11, {starts[3:0], stops[3:0]});
    chk("nack", 8'h00, {7'h00, nack});
    chk("scl slow", 8'h01, {7'h00, per_min >= 2500.0});
    $display("test two-wire write finished");
  endtask

  task automatic t_i2c_read();
    run(1'b0, 1'b1, 7'h7E, 8'h02);
    chk("read count", 8'h03, 8'(rq.size()));
    chk("read 0", 8'h11, rq[0]);
    chk("read 1", 8'h22, rq[1]);
    chk("read 2", 8'h33, rq[2]);
    chk("start stop", 8'h21, {starts[3:0], stops[3:0]});
    chk("host nacked last", 8'h00, {7'h00, i_sensor_model.mack});
    $display("test two-wire read finished");
  endtask

  task automatic t_wrong_addr();
    strap = 1'b0;
    wq = '{8'hAA};
    run(1'b0, 1'b0, 7'h05, 8'h00);
    chk("nack set", 8'h01, {7'h00, nack});
    chk("stop sent", 8'h01, stops[7:0]);
    strap = 1'b1;
    $display("test address mismatch finished");
  endtask

  task automatic t_stretch();
    stretch = 1'b1;
    wq = '{8'h5A};
    run(1'b0, 1'b0, 7'h20, 8'h00);
    stretch = 1'b0;
    chk("mem 20", 8'h5A, i_sensor_model.mem[7'h20]);
    chk("nack", 8'h00, {7'h00, nack});
    chk("scl held", 8'h01, {7'h00, per_min >= 3500.0});
    $display("test clock stretch finished");
  endtask

  task automatic t_refuse();
    dis = 1'b1;
    spi = 1'b0;
    req = 1'b1;
    @(posedge clock_in);
    #1 req = 1'b0;
    chk("refused", 8'h02, {6'h00, refused, busy});
    @(posedge clock_in);
    #1 chk("refused pulse", 8'h00, {7'h00, refused});
    chk("no bus", 8'h00, {7'h00, clk_oe});
    $display("test refuse finished");
  endtask

  task automatic t_spi();
    wq = '{8'hA5, 8'h3C};
    run(1'b1, 1'b0, 7'h10, 8'h01);
    chk("mem 10", 8'hA5, i_sensor_model.mem[7'h10]);
    chk("mem 11", 8'h3C, i_sensor_model.mem[7'h11]);
    chk("select off", 8'h01, {7'h00, sel_n});
    run(1'b1, 1'b1, 7'h10, 8'h01);
    chk("spi read 0", 8'hA5, rq[0]);
    chk("spi read 1", 8'h3C, rq[1]);
    chk("sclk slow", 8'h01, {7'h00, per_min >= 100.0});
    dis = 1'b0;
    $display("test four-wire finished");
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    #1 rst_in = 1'b0;
    @(posedge clock_in);
    #1 t_reset();
    t_i2c_write();
    t_i2c_read();
    t_wrong_addr();
    t_stretch();
    t_refuse();
    t_spi();
    end_sim();
  end
  // hang guard, about two and a half times the expected run
  initial begin
    #1000000;
    failures++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim();
  end
endmodule // sensor_host_tb

`default_nettype wire
